// File: design/pccs_pkg.sv
// shared constants and types for the pc card socket signalling block
package pccs_pkg;

    // clock rate and default strobe timing
    localparam int CLK_MHZ   = 50;
    localparam int SETUP_NS  = 20;
    localparam int STROBE_NS = 100;
    localparam int HOLD_NS   = 20;
    localparam int NS_PER_US = 1000;

    // least time in ns to whole clock cycles, never below one
    function automatic int ns_to_min_cycles(input int ns);
        int r;
        r = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
        if (r < 1) begin
            r = 1;
        end
        return r;
    endfunction : ns_to_min_cycles

    localparam int SETUP_CYC  = ns_to_min_cycles(SETUP_NS);
    localparam int STROBE_CYC = ns_to_min_cycles(STROBE_NS);
    localparam int HOLD_CYC   = ns_to_min_cycles(HOLD_NS);

    // phase counter width
    localparam int CNT_W = 8;

    // flip-flops between a card pin and the logic that reads it
    localparam int SYNC_STAGES = 2;

    // byte lane positions in a lane vector
    localparam int LANE_LO = 0;
    localparam int LANE_HI = 1;

    // level of every active-low pin at rest
    localparam logic PIN_IDLE = 1'h1;

    // target space of a transaction
    typedef enum logic [1:0] {
        SPACE_COMMON,
        SPACE_ATTR,
        SPACE_IO
    } pccs_space_e;

    // transaction phases
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } pccs_state_e;

endpackage : pccs_pkg

// File: design/pccs_sync.sv
// two-flop synchroniser for one card input pin
module pccs_sync #(
    parameter logic RST_VAL = 1'h1
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // pin and synchronised level
    input  wire logic pinIn,
    output logic      syncOut
);

    logic stage1;

    // first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            stage1  <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            stage1  <= pinIn;
            syncOut <= stage1;
        end
    end

endmodule : pccs_sync

// File: design/pccs_socket.sv
// pc card socket strobe and select sequencer
// Behaviour
// - socket select low addresses socket zero, high addresses socket one.
// - socket select changes with address timing, steady through the transfer.
// - attribute select is asserted for memory transfers to attribute space.
// - card enable two drives high byte lane, card enable one low lane.
// - memory read strobe pulses for common memory and attribute reads.
// - memory write strobe pulses for common memory and attribute writes.
// - io write strobe pulses for every write to io space.
// - io read strobe pulses for every read from io space.
// - card holding wait low stretches the active strobe.
// - card width acknowledge is sampled to choose 8 or 16 bit io.
module pccs_socket #(
    parameter int SETUP_CYC  = pccs_pkg::SETUP_CYC,
    parameter int STROBE_CYC = pccs_pkg::STROBE_CYC,
    parameter int HOLD_CYC   = pccs_pkg::HOLD_CYC
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // transaction request
    input  wire logic       reqValid,
    output logic            reqReady,
    input  wire logic       reqWrite,
    input  wire logic [1:0] reqSpace,
    input  wire logic       reqSocket,
    input  wire logic [1:0] reqLanes,
    // transaction completion
    output logic            doneValid,
    output logic            doneIo16,
    output logic [1:0]      doneLanes,
    // card pins
    output logic            card_mem_read_strobe_n,
    output logic            card_mem_write_strobe_n,
    output logic            card_io_write_strobe_n,
    output logic            card_io_read_strobe_n,
    output logic            card_high_lane_enable_n,
    output logic            card_low_lane_enable_n,
    output logic            socket_select,
    output logic            attribute_space_select_n,
    input  wire logic       card_wait_n,
    input  wire logic       card_io_width16_ack_n
);

    typedef logic [pccs_pkg::CNT_W-1:0] pccs_cnt_t;

    typedef struct packed {
        pccs_pkg::pccs_state_e state;
        pccs_cnt_t             cnt;
        pccs_pkg::pccs_space_e space;
        logic                  write;
        logic                  widthDone;
        logic                  io16;
        logic                  doneValid;
        logic [1:0]            usedLanes;
        logic                  socket;
        logic                  attrN;
        logic                  laneHiN;
        logic                  laneLoN;
        logic                  memRdN;
        logic                  memWrN;
        logic                  ioRdN;
        logic                  ioWrN;
    } pccs_st_s;

    localparam pccs_st_s ST_RESET = '{
        state:     pccs_pkg::ST_IDLE,
        cnt:       '0,
        space:     pccs_pkg::SPACE_COMMON,
        write:     1'h0,
        widthDone: 1'h0,
        io16:      1'h0,
        doneValid: 1'h0,
        usedLanes: 2'h0,
        socket:    1'h0,
        attrN:     pccs_pkg::PIN_IDLE,
        laneHiN:   pccs_pkg::PIN_IDLE,
        laneLoN:   pccs_pkg::PIN_IDLE,
        memRdN:    pccs_pkg::PIN_IDLE,
        memWrN:    pccs_pkg::PIN_IDLE,
        ioRdN:     pccs_pkg::PIN_IDLE,
        ioWrN:     pccs_pkg::PIN_IDLE
    };

    localparam pccs_cnt_t SETUP_LOAD  = pccs_cnt_t'(SETUP_CYC - 1);
    localparam pccs_cnt_t STROBE_LOAD = pccs_cnt_t'(STROBE_CYC - 1);
    localparam pccs_cnt_t HOLD_LOAD   = pccs_cnt_t'(HOLD_CYC - 1);
    localparam pccs_cnt_t CNT_ONE     = pccs_cnt_t'(1);
    // io first setup lasts until the synchronised ack reflects the enabled card
    localparam pccs_cnt_t ACK_LOAD    = pccs_cnt_t'((SETUP_CYC - 1 > pccs_pkg::SYNC_STAGES) ? SETUP_CYC - 1 : pccs_pkg::SYNC_STAGES);

    pccs_st_s st;
    pccs_st_s next_st;
    logic     waitSync;
    logic     ackSync;
    logic     strobeAny;

    // synchronise the card's wait and width acknowledge pins
    pccs_sync #(.RST_VAL(pccs_pkg::PIN_IDLE)) uWaitSync (
        .mclk    (mclk),
        .resetn  (resetn),
        .pinIn   (card_wait_n),
        .syncOut (waitSync)
    );

    pccs_sync #(.RST_VAL(pccs_pkg::PIN_IDLE)) uAckSync (
        .mclk    (mclk),
        .resetn  (resetn),
        .pinIn   (card_io_width16_ack_n),
        .syncOut (ackSync)
    );

    // phase sequencer
    always_comb begin
        next_st           = st;
        next_st.doneValid = 1'h0;
        case (st.state)
            pccs_pkg::ST_IDLE: begin
                if (reqValid) begin
                    next_st.state     = pccs_pkg::ST_SETUP;
                    next_st.cnt       = (reqSpace == pccs_pkg::SPACE_IO) ? ACK_LOAD : SETUP_LOAD;
                    next_st.write     = reqWrite;
                    next_st.space     = pccs_pkg::pccs_space_e'(reqSpace);
                    next_st.socket    = reqSocket;
                    next_st.attrN     = !(reqSpace == pccs_pkg::SPACE_ATTR);
                    next_st.laneHiN   = !reqLanes[pccs_pkg::LANE_HI];
                    next_st.laneLoN   = !reqLanes[pccs_pkg::LANE_LO];
                    next_st.widthDone = (reqSpace != pccs_pkg::SPACE_IO);
                    next_st.io16      = 1'h0;
                end
            end
            pccs_pkg::ST_SETUP: begin
                if (st.cnt != '0) begin
                    next_st.cnt = st.cnt - CNT_ONE;
                end else if (!st.widthDone) begin
                    // io width: drop the high lane when the low lane is also enabled unless the card acks 16 bit, then settle again
                    next_st.widthDone = 1'h1;
                    next_st.io16      = !ackSync;
                    if (ackSync && !st.laneLoN) begin
                        next_st.laneHiN = pccs_pkg::PIN_IDLE;
                    end
                    next_st.cnt = SETUP_LOAD;
                end else begin
                    next_st.state = pccs_pkg::ST_STROBE;
                    next_st.cnt   = STROBE_LOAD;
                    if (st.space == pccs_pkg::SPACE_IO) begin
                        next_st.ioWrN = !st.write;
                        next_st.ioRdN = st.write;
                    end else begin
                        next_st.memWrN = !st.write;
                        next_st.memRdN = st.write;
                    end
                end
            end
            pccs_pkg::ST_STROBE: begin
                if (st.cnt != '0) begin
                    next_st.cnt = st.cnt - CNT_ONE;
                end else if (waitSync) begin
                    // release only once the card no longer holds wait low
                    next_st.state  = pccs_pkg::ST_HOLD;
                    next_st.cnt    = HOLD_LOAD;
                    next_st.memRdN = pccs_pkg::PIN_IDLE;
                    next_st.memWrN = pccs_pkg::PIN_IDLE;
                    next_st.ioRdN  = pccs_pkg::PIN_IDLE;
                    next_st.ioWrN  = pccs_pkg::PIN_IDLE;
                end
            end
            pccs_pkg::ST_HOLD: begin
                if (st.cnt != '0) begin
                    next_st.cnt = st.cnt - CNT_ONE;
                end else begin
                    // selects held past the strobe, then enables return to rest
                    next_st.state     = pccs_pkg::ST_IDLE;
                    next_st.doneValid = 1'h1;
                    next_st.usedLanes = {!st.laneHiN, !st.laneLoN};
                    next_st.attrN     = pccs_pkg::PIN_IDLE;
                    next_st.laneHiN   = pccs_pkg::PIN_IDLE;
                    next_st.laneLoN   = pccs_pkg::PIN_IDLE;
                end
            end
            default: begin
                next_st = ST_RESET;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state flops
    assign reqReady                 = (st.state == pccs_pkg::ST_IDLE);
    assign doneValid                = st.doneValid;
    assign doneIo16                 = st.io16;
    assign doneLanes                = st.usedLanes;
    assign card_mem_read_strobe_n   = st.memRdN;
    assign card_mem_write_strobe_n  = st.memWrN;
    assign card_io_write_strobe_n   = st.ioWrN;
    assign card_io_read_strobe_n    = st.ioRdN;
    assign card_high_lane_enable_n  = st.laneHiN;
    assign card_low_lane_enable_n   = st.laneLoN;
    assign socket_select            = st.socket;
    assign attribute_space_select_n = st.attrN;
    assign strobeAny = !(st.memRdN && st.memWrN && st.ioRdN && st.ioWrN);

    // checks on the card-side signalling
    localparam int MAX_START = 64;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_sock_value;
        (reqValid && reqReady) |=> (socket_select == $past(reqSocket));
    endproperty
    a_sock_value: assert property (p_sock_value) else $error("socket select not from request");

    property p_sel_stable;
        (strobeAny && $past(strobeAny)) |-> ($stable(socket_select) && $stable(attribute_space_select_n));
    endproperty
    a_sel_stable: assert property (p_sel_stable) else $error("select moved under strobe");

    property p_attr;
        strobeAny |-> (attribute_space_select_n == (st.space != pccs_pkg::SPACE_ATTR));
    endproperty
    a_attr: assert property (p_attr) else $error("attribute select wrong");

    property p_lane_lo;
        (reqValid && reqReady) |=> (card_low_lane_enable_n == !$past(reqLanes[pccs_pkg::LANE_LO]));
    endproperty
    a_lane_lo: assert property (p_lane_lo) else $error("low lane enable wrong");

    property p_mem_rd;
        (reqValid && reqReady && !reqWrite && reqSpace != pccs_pkg::SPACE_IO)
            |-> ##[1:MAX_START] !card_mem_read_strobe_n;
    endproperty
    a_mem_rd: assert property (p_mem_rd) else $error("no memory read strobe");

    property p_mem_wr;
        (reqValid && reqReady && reqWrite && reqSpace != pccs_pkg::SPACE_IO)
            |-> ##[1:MAX_START] !card_mem_write_strobe_n;
    endproperty
    a_mem_wr: assert property (p_mem_wr) else $error("no memory write strobe");

    property p_io_wr;
        (reqValid && reqReady && reqWrite && reqSpace == pccs_pkg::SPACE_IO)
            |-> ##[1:MAX_START] !card_io_write_strobe_n;
    endproperty
    a_io_wr: assert property (p_io_wr) else $error("no io write strobe");

    property p_io_rd;
        (reqValid && reqReady && !reqWrite && reqSpace == pccs_pkg::SPACE_IO)
            |-> ##[1:MAX_START] !card_io_read_strobe_n;
    endproperty
    a_io_rd: assert property (p_io_rd) else $error("no io read strobe");

    property p_wait;
        (strobeAny && !waitSync) |=> strobeAny;
    endproperty
    a_wait: assert property (p_wait) else $error("strobe ended during wait");

    property p_io16;
        (!card_io_read_strobe_n || !card_io_write_strobe_n) && !card_high_lane_enable_n
            && !card_low_lane_enable_n |-> st.io16;
    endproperty
    a_io16: assert property (p_io16) else $error("16 bit io without acknowledge");

    property p_one_strobe;
        $onehot0({!st.memRdN, !st.memWrN, !st.ioRdN, !st.ioWrN}) && !(reqReady && strobeAny);
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("strobe overlap or idle strobe");

    property p_settle;
        $rose(strobeAny) |-> ($stable(card_high_lane_enable_n) && $stable(card_low_lane_enable_n)
            && $stable(socket_select));
    endproperty
    a_settle: assert property (p_settle) else $error("enables moved with strobe");

    c_io16: cover property (!card_io_read_strobe_n && st.io16);
    c_wait: cover property (strobeAny && !waitSync ##1 strobeAny);
    c_attr_wr: cover property (!card_mem_write_strobe_n && !attribute_space_select_n);

endmodule : pccs_socket

// File: tb/pccs_card_model.sv
// behavioural card behind the socket: wait stretching and io width acknowledge
module pccs_card_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // strobes and lane enables from the socket
    input  wire logic [3:0] strobeN,
    input  wire logic [1:0] laneN,
    // behaviour chosen by the bench
    input  wire logic       ack16Mode,
    input  wire logic [7:0] waitLen,
    // card answers
    output logic            card_wait_n,
    output logic            card_io_width16_ack_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       anyPrev;
    logic [7:0] waitCnt;

    // hold wait low for the chosen span once a strobe falls
    always @(posedge mclk) begin
        if (!resetn) begin
            anyPrev <= 1'b0;
            waitCnt <= 8'h00;
        end else begin
            anyPrev <= ~&strobeN;
            if (~&strobeN && !anyPrev) begin
                waitCnt <= waitLen;
            end else if (waitCnt != 8'h00) begin
                waitCnt <= waitCnt - 8'h01;
            end
        end
    end

    // wait line rests high through its pull-up when not held
    assign card_wait_n = (waitCnt == 8'h00);
    // width acknowledge only while the card is enabled, pulled high otherwise
    assign card_io_width16_ack_n = !(ack16Mode && !(&laneN));
endmodule : pccs_card_model

// File: tb/tb.sv
// self-checking bench for the pc card socket sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk, resetn, reqValid, reqReady, reqWrite, reqSocket, doneValid, doneIo16;
    logic [1:0] reqSpace, reqLanes, doneLanes;
    logic       memRdN, memWrN, ioWrN, ioRdN, hiN, loN, sockSel, attrN, waitN, ack16N, ack16Mode;
    logic [7:0] waitLen;
    int         errors, checks;

    pccs_socket dut (.mclk(mclk), .resetn(resetn), .reqValid(reqValid), .reqReady(reqReady),
        .reqWrite(reqWrite), .reqSpace(reqSpace), .reqSocket(reqSocket), .reqLanes(reqLanes),
        .doneValid(doneValid), .doneIo16(doneIo16), .doneLanes(doneLanes),
        .card_mem_read_strobe_n(memRdN), .card_mem_write_strobe_n(memWrN),
        .card_io_write_strobe_n(ioWrN), .card_io_read_strobe_n(ioRdN),
        .card_high_lane_enable_n(hiN), .card_low_lane_enable_n(loN), .socket_select(sockSel),
        .attribute_space_select_n(attrN), .card_wait_n(waitN), .card_io_width16_ack_n(ack16N));

    pccs_card_model card (.mclk(mclk), .resetn(resetn), .strobeN({memRdN, memWrN, ioWrN, ioRdN}),
        .laneN({hiN, loN}), .ack16Mode(ack16Mode), .waitLen(waitLen), .card_wait_n(waitN),
        .card_io_width16_ack_n(ack16N));

    // compare one value and count it
    task automatic expect1(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : expect1

    // print the counts and the verdict, then stop
    task automatic final_report();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // one transfer: captures the strobe, its length and the selects seen as it falls
    task automatic xfer(input logic wr, input logic [1:0] sp, input logic sk, input logic [1:0] ln,
                        output int len, output logic [3:0] which, output logic [3:0] pins,
                        output logic io16, output logic [1:0] dl);
        logic [3:0] stb;
        logic       seen;
        len = 0;
        which = 4'h0;
        pins = 4'h0;
        io16 = 1'b0;
        dl = 2'h0;
        seen = 1'b0;
        @(posedge mclk);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqSpace <= sp;
        reqSocket <= sk;
        reqLanes <= ln;
        @(posedge mclk);
        reqValid <= 1'b0;
        for (int n = 0; n < 100; n++) begin
            @(negedge mclk);
            stb = ~{memRdN, memWrN, ioWrN, ioRdN};
            if (stb != 4'h0) begin
                if (len == 0) begin
                    which = stb;
                    pins = {sockSel, attrN, hiN, loN};
                end else begin
                    expect1({stb, sockSel, attrN, hiN, loN}, {which, pins});
                end
                len++;
            end
            if (doneValid === 1'b1) begin
                io16 = doneIo16;
                seen = 1'b1;
                dl = doneLanes;
                expect1({memRdN, memWrN, ioWrN, ioRdN, hiN, loN, attrN}, 8'h7F);
                break;
            end
        end
        expect1(8'(seen), 8'h01);
    endtask : xfer

    // pins at rest while reset is held
    task automatic test_reset();
        expect1({memRdN, memWrN, ioWrN, ioRdN, hiN, loN, attrN}, 8'h7F);
        expect1({sockSel, reqReady, doneValid}, 8'h02);
    endtask : test_reset

    // memory reads and writes over every space, socket and lane choice
    task automatic test_memory();
        int len;
        logic [3:0] which, pins;
        logic io16;
        logic [1:0] dl;
        for (int i = 0; i < 8; i++) begin
            logic [1:0] sp, ln;
            sp = (i < 4) ? 2'(i % 2) : 2'h3;
            ln = 2'(i % 3 + 1);
            xfer(i[1], sp, i[2], ln, len, which, pins, io16, dl);
            expect1(8'(which), i[1] ? 8'h04 : 8'h08);
            expect1(8'(len), 8'(pccs_pkg::STROBE_CYC));
            expect1(8'(pins), {4'h0, i[2], sp != 2'h1, ~ln});
            expect1({5'h00, io16, dl}, {6'h00, ln});
        end
    endtask : test_memory

    // io transfers with and without the width acknowledge
    task automatic test_io();
        int len;
        logic [3:0] which, pins;
        logic io16;
        logic [1:0] dl;
        for (int i = 0; i < 6; i++) begin
            logic [1:0] ln;
            ln = 2'(i % 3 + 1);
            ack16Mode <= i[0];
            xfer(i[1], 2'h2, i[0], ln, len, which, pins, io16, dl);
            expect1(8'(which), i[1] ? 8'h02 : 8'h01);
            expect1(8'(pins), {4'h0, i[0], 1'b1, (ln == 2'h3 && !i[0]) | ~ln[1], ~ln[0]});
            expect1({5'h00, io16, dl}, {5'h00, i[0], (ln == 2'h3 && !i[0]) ? 2'h1 : ln});
        end
        ack16Mode <= 1'b0;
    endtask : test_io

    // card holds wait low and the read strobe stretches
    task automatic test_wait();
        int len;
        logic [3:0] which, pins;
        logic io16;
        logic [1:0] dl;
        waitLen <= 8'h08;
        xfer(1'b0, 2'h0, 1'b0, 2'h3, len, which, pins, io16, dl);
        expect1(8'(len > 8), 8'h01);
        expect1(8'(which), 8'h08);
        waitLen <= 8'h00;
    endtask : test_wait

    // clock generation
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // watchdog against a hung transfer
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        final_report();
    end

    // main sequence
    initial begin
        {resetn, reqValid, reqWrite, reqSocket, ack16Mode} = 5'h00;
        {reqSpace, reqLanes} = 4'h0;
        waitLen = 8'h00;
        errors = 0;
        checks = 0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        test_reset();
        @(posedge mclk);
        resetn <= 1'b1;
        test_memory();
        test_io();
        test_wait();
        final_report();
    end
endmodule : tb
